// *** src/pin_mux_pkg.sv ***
// package: constants and types for the decoder / serial pin mux
package pin_mux_pkg;
	localparam int NUM_PINS = 6;
	// pin indices
	localparam int PIN_INDEX = 0;
	localparam int PIN_HOME = 1;
	localparam int PIN_SCLK = 2;
	localparam int PIN_MOSI = 3;
	localparam int PIN_MISO = 4;
	localparam int PIN_SS = 5;
	// pull-up register bit positions
	localparam int PC_PU_INDEX_BIT = 6;
	localparam int PC_PU_HOME_BIT = 7;
	localparam int PE_PU_SCLK_BIT = 4;
	localparam int PE_PU_MOSI_BIT = 5;
	localparam int PE_PU_MISO_BIT = 6;
	localparam int PE_PU_SS_BIT = 7;
	// reset values
	localparam logic [7:0] PULLUP_RESET = 8'hFF;
	localparam logic [5:0] GPIO_DIR_RESET = 6'h00;
	localparam logic [5:0] GPIO_OUT_RESET = 6'h00;
	localparam logic [5:0] PAD_RESET = 6'h3F;
	typedef enum logic [1:0] {
		FUNC_PERIPH = 2'b00,
		FUNC_TIMER = 2'b01,
		FUNC_GPIO = 2'b10
	} func_sel_type;
endpackage

// *** src/pad_ctrl_if.sv ***
// interface: per-pin pad drive bundle between mux and pad stage
`timescale 1ns/1ps
interface pad_ctrl_if;
	logic [5:0] drive_val;
	logic [5:0] drive_oe_n;
	logic [5:0] pad_sync;
	modport mux (output drive_val, output drive_oe_n, input pad_sync);
	modport pad (input drive_val, input drive_oe_n, output pad_sync);
endinterface

// *** src/pad_stage.sv ***
// module: pad input synchronisers and registered pad drive
`timescale 1ns/1ps
module pad_stage (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [5:0] pad_in,
	output logic [5:0] pad_out,
	output logic [5:0] pad_oe_n_out,
	pad_ctrl_if.pad ctrl
);
	import pin_mux_pkg::*;
	logic [5:0] meta_ff;
	logic [5:0] sync_ff;
	logic [5:0] out_ff;
	logic [5:0] oe_n_ff;

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			meta_ff <= PAD_RESET;
			sync_ff <= PAD_RESET;
		end else begin
			meta_ff <= pad_in;
			sync_ff <= meta_ff;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			out_ff <= '0;
			oe_n_ff <= '1;
		end else begin
			out_ff <= ctrl.drive_val;
			oe_n_ff <= ctrl.drive_oe_n;
		end
	end

	assign ctrl.pad_sync = sync_ff;
	assign pad_out = out_ff;
	assign pad_oe_n_out = oe_n_ff;
endmodule // pad_stage

// *** src/decoder_spi_pin_mux.sv ***
// module: pin mux and pull-up control for decoder 0 and serial 0 pins
`timescale 1ns/1ps
// Functional notes
// - after reset index and home pins select decoder 0 function
// - after reset four serial pins select serial interface 0 functions
// - every pin usable as general-purpose with per-pin direction
// - index/home pull-ups on by default, cleared by port C bits 6, 7
// - serial pin pull-ups on by default, cleared by port E bits 4-7
// - serial clock driven as master, taken as input clock as slave
// - master presents data-out half a clock before slave samples
// - slave presents data-in half a clock before master samples
// - unselected slave leaves its data-in line undriven
// - external master asserts active-low select to start received transfer
module decoder_spi_pin_mux (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [5:0] pad_in,
	output logic [5:0] pad_out,
	output logic [5:0] pad_oe_n_out,
	output logic [5:0] pad_pullup_en_out,
	input wire logic [7:0] port_c_pullup_ctrl_in,
	input wire logic [7:0] port_e_pullup_ctrl_in,
	input wire logic pullup_wr_in,
	input wire logic [11:0] func_sel_in,
	input wire logic func_sel_wr_in,
	input wire logic [5:0] gpio_dir_in,
	input wire logic [5:0] gpio_out_in,
	input wire logic gpio_wr_in,
	output logic [5:0] gpio_in_out,
	input wire logic [1:0] timer_a_chan_out_in,
	input wire logic [1:0] timer_a_chan_oe_in,
	output logic [1:0] timer_a_chan_in_out,
	output logic decoder0_index_in_out,
	output logic decoder0_home_in_out,
	input wire logic ser0_master_in,
	input wire logic ser0_clock_drive_in,
	input wire logic ser0_data_out_drive_in,
	input wire logic ser0_data_in_drive_in,
	input wire logic ser0_slave_drive_en_in,
	output logic ser0_clock_pin_out,
	output logic ser0_data_out_pin_out,
	output logic ser0_data_in_pin_out,
	output logic ser0_select_n_out
);
	import pin_mux_pkg::*;

	pad_ctrl_if ctrl ();

	func_sel_type func_ff [NUM_PINS];
	logic [7:0] pu_c_ff;
	logic [7:0] pu_e_ff;
	logic [5:0] dir_ff;
	logic [5:0] gout_ff;
	logic [5:0] pu_en_ff;
	logic [5:0] gin_ff;
	logic [1:0] tin_ff;
	logic idx_ff;
	logic home_ff;
	logic sclk_ff;
	logic mosi_ff;
	logic miso_ff;
	logic ss_n_ff;
	logic [5:0] nxt_val;
	logic [5:0] nxt_oe_n;
	logic sel_n;

	pad_stage u_pad (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.pad_in(pad_in),
		.pad_out(pad_out),
		.pad_oe_n_out(pad_oe_n_out),
		.ctrl(ctrl)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_func
			always_ff @(posedge clk_sys_in) begin
				if (!resetn_in) begin
					func_ff[gi] <= FUNC_PERIPH;
				end else if (func_sel_wr_in) begin
					if (func_sel_in[2*gi +: 2] == FUNC_TIMER && gi < 2) begin
						func_ff[gi] <= FUNC_TIMER;
					end else if (func_sel_in[2*gi +: 2] == FUNC_GPIO) begin
						func_ff[gi] <= FUNC_GPIO;
					end else begin
						func_ff[gi] <= FUNC_PERIPH;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			pu_c_ff <= PULLUP_RESET;
			pu_e_ff <= PULLUP_RESET;
		end else if (pullup_wr_in) begin
			pu_c_ff <= port_c_pullup_ctrl_in;
			pu_e_ff <= port_e_pullup_ctrl_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			pu_en_ff <= PAD_RESET;
		end else begin
			pu_en_ff <= {pu_e_ff[PE_PU_SS_BIT], pu_e_ff[PE_PU_MISO_BIT], pu_e_ff[PE_PU_MOSI_BIT],
				pu_e_ff[PE_PU_SCLK_BIT], pu_c_ff[PC_PU_HOME_BIT], pu_c_ff[PC_PU_INDEX_BIT]};
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			dir_ff <= GPIO_DIR_RESET;
			gout_ff <= GPIO_OUT_RESET;
		end else if (gpio_wr_in) begin
			dir_ff <= gpio_dir_in;
			gout_ff <= gpio_out_in;
		end
	end

	assign sel_n = ctrl.pad_sync[PIN_SS];

	always_comb begin
		nxt_val = '0;
		nxt_oe_n = '1;
		for (int i = 0; i < NUM_PINS; i++) begin
			unique case (func_ff[i])
				FUNC_GPIO: begin
					nxt_val[i] = gout_ff[i];
					nxt_oe_n[i] = ~dir_ff[i];
				end
				FUNC_TIMER: begin
					if (i < 2) begin
						nxt_val[i] = timer_a_chan_out_in[i];
						nxt_oe_n[i] = ~timer_a_chan_oe_in[i];
					end
				end
				FUNC_PERIPH: begin
				end
				default: begin
				end
			endcase
		end
		if (func_ff[PIN_SCLK] == FUNC_PERIPH) begin
			nxt_val[PIN_SCLK] = ser0_clock_drive_in;
			nxt_oe_n[PIN_SCLK] = ~ser0_master_in;
		end
		if (func_ff[PIN_MOSI] == FUNC_PERIPH) begin
			nxt_val[PIN_MOSI] = ser0_data_out_drive_in;
			nxt_oe_n[PIN_MOSI] = ~ser0_master_in;
		end
		if (func_ff[PIN_MISO] == FUNC_PERIPH) begin
			nxt_val[PIN_MISO] = ser0_data_in_drive_in;
			nxt_oe_n[PIN_MISO] = ser0_master_in | sel_n | ~ser0_slave_drive_en_in;
		end
	end

	assign ctrl.drive_val = nxt_val;
	assign ctrl.drive_oe_n = nxt_oe_n;

	// decoder and serial inputs parked inactive when pin not on that function; timer and gpio inputs always follow the pads
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			idx_ff <= 1'b1;
			home_ff <= 1'b1;
			tin_ff <= 2'h3;
			gin_ff <= PAD_RESET;
		end else begin
			idx_ff <= (func_ff[PIN_INDEX] == FUNC_PERIPH) ? ctrl.pad_sync[PIN_INDEX] : 1'b1;
			home_ff <= (func_ff[PIN_HOME] == FUNC_PERIPH) ? ctrl.pad_sync[PIN_HOME] : 1'b1;
			tin_ff <= ctrl.pad_sync[1:0];
			gin_ff <= ctrl.pad_sync;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			sclk_ff <= 1'b1;
			mosi_ff <= 1'b1;
			miso_ff <= 1'b1;
			ss_n_ff <= 1'b1;
		end else begin
			sclk_ff <= (func_ff[PIN_SCLK] == FUNC_PERIPH) ? ctrl.pad_sync[PIN_SCLK] : 1'b1;
			mosi_ff <= (func_ff[PIN_MOSI] == FUNC_PERIPH) ? ctrl.pad_sync[PIN_MOSI] : 1'b1;
			miso_ff <= (func_ff[PIN_MISO] == FUNC_PERIPH) ? ctrl.pad_sync[PIN_MISO] : 1'b1;
			ss_n_ff <= (func_ff[PIN_SS] == FUNC_PERIPH) ? sel_n : 1'b1;
		end
	end

	assign pad_pullup_en_out = pu_en_ff;
	assign gpio_in_out = gin_ff;
	assign timer_a_chan_in_out = tin_ff;
	assign decoder0_index_in_out = idx_ff;
	assign decoder0_home_in_out = home_ff;
	assign ser0_clock_pin_out = sclk_ff;
	assign ser0_data_out_pin_out = mosi_ff;
	assign ser0_data_in_pin_out = miso_ff;
	assign ser0_select_n_out = ss_n_ff;
endmodule // decoder_spi_pin_mux

// *** dv/pin_mux_properties.sv ***
// checker: port properties of the decoder and serial pin mux
`timescale 1ns/1ps
module pin_mux_properties (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [5:0] pad_out,
	input wire logic [5:0] pad_oe_n_out,
	input wire logic [5:0] pad_pullup_en_out,
	input wire logic [7:0] port_c_pullup_ctrl_in,
	input wire logic [7:0] port_e_pullup_ctrl_in,
	input wire logic pullup_wr_in,
	input wire logic [11:0] func_sel_in,
	input wire logic func_sel_wr_in,
	input wire logic decoder0_index_in_out,
	input wire logic ser0_master_in,
	input wire logic ser0_clock_drive_in
);
	logic [11:0] fs_ff, fsd_ff;
	logic run_ff, mst_ff;
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);
	// shadow of function selects and one-cycle delays
	always_ff @(posedge clk_sys_in) begin
		fs_ff <= !resetn_in ? 12'h000 : func_sel_wr_in ? func_sel_in : fs_ff;
		fsd_ff <= fs_ff;
		run_ff <= resetn_in;
		mst_ff <= ser0_master_in;
	end
	reset_release_a: assert property ($rose(resetn_in) |-> pad_oe_n_out == 6'h3F && pad_pullup_en_out == 6'h3F)
		else $error("pads not idle after reset");
	index_pullup_a: assert property (pullup_wr_in |-> ##2
		pad_pullup_en_out[1:0] == $past(port_c_pullup_ctrl_in[7:6], 2)) else $error("index pull-up mismatch");
	serial_pullup_a: assert property (pullup_wr_in |-> ##2
		pad_pullup_en_out[5:2] == $past(port_e_pullup_ctrl_in[7:4], 2)) else $error("serial pull-up mismatch");
	clock_dir_a: assert property (run_ff && fsd_ff[5:4] != 2'b10 |-> pad_oe_n_out[2] == !mst_ff)
		else $error("clock pin direction wrong");
	clock_drive_a: assert property (run_ff && mst_ff && fsd_ff[5:4] != 2'b10 |->
		pad_out[2] == $past(ser0_clock_drive_in)) else $error("clock pin value wrong");
	mosi_dir_a: assert property (run_ff && fsd_ff[7:6] != 2'b10 |-> pad_oe_n_out[3] == !mst_ff)
		else $error("data-out pin direction wrong");
	miso_release_a: assert property (fsd_ff[9:8] != 2'b10 && !pad_oe_n_out[4] |-> run_ff && !mst_ff)
		else $error("data-in pin driven while master");
	index_forced_a: assert property ((fs_ff[1:0] == 2'b10) [*3] |=> decoder0_index_in_out)
		else $error("index not forced inactive");
	cover property (mst_ff && !pad_oe_n_out[2]);
	cover property (!pad_oe_n_out[4]);
	cover property (pullup_wr_in);
endmodule // pin_mux_properties
bind decoder_spi_pin_mux pin_mux_properties u_props (.clk_sys_in, .resetn_in, .pad_out, .pad_oe_n_out,
	.pad_pullup_en_out, .port_c_pullup_ctrl_in, .port_e_pullup_ctrl_in, .pullup_wr_in, .func_sel_in,
	.func_sel_wr_in, .decoder0_index_in_out, .ser0_master_in, .ser0_clock_drive_in);

// *** dv/pad_partner.sv ***
// partner: external peers and sensors on the six pad wires
`timescale 1ns/1ps
module pad_partner (
	input wire logic clk_sys_in,
	input wire logic [5:0] pad_out_in,
	input wire logic [5:0] pad_oe_n_in,
	input wire logic [5:0] pull_in,
	input wire logic [5:0] ext_val_in,
	input wire logic [5:0] ext_en_in,
	output logic [5:0] pad_level_out
);
	logic [5:0] last_ff = 6'h00;
	// remember the level each wire had while someone drove it
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < 6; i++) begin
			if (!pad_oe_n_in[i] || ext_en_in[i]) begin
				last_ff[i] <= pad_level_out[i];
			end
		end
	end
	// released wire reads high with pull-up on, else the inverse of its last driven level
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pad_level_out[i] = !pad_oe_n_in[i] ? pad_out_in[i] : ext_en_in[i] ? ext_val_in[i] : pull_in[i] | !last_ff[i];
		end
	end
endmodule // pad_partner

// *** dv/testbench.sv ***
// testbench: directed pin mux tests
`timescale 1ns/1ps
module testbench;
	import pin_mux_pkg::*;
	logic clk_sys_in = 0, resetn_in = 0, pullup_wr_in = 0, func_sel_wr_in = 0, gpio_wr_in = 0, ser0_master_in = 0;
	logic ser0_clock_drive_in = 0, ser0_data_out_drive_in = 0, ser0_data_in_drive_in = 1, ser0_slave_drive_en_in = 0;
	logic [7:0] port_c_pullup_ctrl_in = 8'hFF, port_e_pullup_ctrl_in = 8'hFF;
	logic [11:0] func_sel_in = 12'h000;
	logic [5:0] gpio_dir_in = 6'h00, gpio_out_in = 6'h00, ext_val = 6'h00, ext_en = 6'h23;
	logic [5:0] pad_in, pad_out, oe_n, pu, gpio_in, core;
	logic [1:0] ta_out = 2'h2, ta_oe = 2'h3;
	logic [1:0] tin;
	int failures = 0, num_checks = 0;
	decoder_spi_pin_mux u_dut (.clk_sys_in, .resetn_in, .pad_in, .pad_out, .pad_oe_n_out(oe_n), .pad_pullup_en_out(pu),
		.port_c_pullup_ctrl_in, .port_e_pullup_ctrl_in, .pullup_wr_in, .func_sel_in, .func_sel_wr_in, .gpio_dir_in,
		.gpio_out_in, .gpio_wr_in, .gpio_in_out(gpio_in), .timer_a_chan_out_in(ta_out), .timer_a_chan_oe_in(ta_oe),
		.timer_a_chan_in_out(tin), .decoder0_index_in_out(core[0]), .decoder0_home_in_out(core[1]), .ser0_master_in,
		.ser0_clock_drive_in, .ser0_data_out_drive_in, .ser0_data_in_drive_in, .ser0_slave_drive_en_in,
		.ser0_clock_pin_out(core[2]), .ser0_data_out_pin_out(core[3]), .ser0_data_in_pin_out(core[4]),
		.ser0_select_n_out(core[5]));
	pad_partner u_peer (.clk_sys_in, .pad_out_in(pad_out), .pad_oe_n_in(oe_n), .pull_in(pu), .ext_val_in(ext_val),
		.ext_en_in(ext_en), .pad_level_out(pad_in));
	always #20 clk_sys_in = !clk_sys_in;
	task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task automatic wr(input int k, input logic [11:0] a, input logic [7:0] b);
		func_sel_in = a;
		gpio_dir_in = a[5:0];
		gpio_out_in = b[5:0];
		port_c_pullup_ctrl_in = a[7:0];
		port_e_pullup_ctrl_in = b;
		{gpio_wr_in, pullup_wr_in, func_sel_wr_in} = 3'b001 << k;
		cyc(1);
		{gpio_wr_in, pullup_wr_in, func_sel_wr_in} = 3'b000;
		cyc(3);
	endtask
	task automatic finish_test;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		cyc(1500);
		failures++;
		finish_test;
	end
	initial begin
		cyc(6);
		resetn_in = 1;
		cyc(1);
		chk(oe_n, PAD_RESET);
		chk(pu, PULLUP_RESET[5:0]);
		cyc(4);
		chk(core, 6'h1C);
		$display("test reset done");
		wr(1, 12'h040, 8'hA0);
		chk(pu, 6'h29);
		wr(1, 12'h0BF, 8'h5F);
		chk(pu, 6'h16);
		wr(1, 12'h0FF, 8'hFF);
		$display("test pullup done");
		ser0_master_in = 1;
		ser0_clock_drive_in = 1;
		ext_en = 6'h10;
		ext_val = 6'h10;
		cyc(4);
		chk(oe_n, 6'h33);
		chk(core, 6'h37);
		{ser0_clock_drive_in, ser0_data_out_drive_in} = 2'b01;
		cyc(2);
		chk(pad_out & 6'h0C, 6'h08);
		$display("test master done");
		ser0_master_in = 0;
		ser0_slave_drive_en_in = 1;
		ext_en = 6'h2C;
		ext_val = 6'h04;
		cyc(5);
		chk(oe_n, 6'h2F);
		chk(core, 6'h17);
		ext_val = 6'h24;
		cyc(5);
		chk(oe_n, 6'h3F);
		$display("test slave done");
		wr(0, 12'hAAA, 8'h00);
		wr(2, 12'h00F, 8'h05);
		chk(oe_n, 6'h30);
		chk(pad_out & 6'h0F, 6'h05);
		cyc(2);
		chk(gpio_in, 6'h35);
		chk(core, 6'h3F);
		wr(0, 12'hC15, 8'h00);
		chk(oe_n, 6'h3C);
		chk(pad_out & 6'h03, 6'h02);
		ser0_master_in = 1;
		ta_oe = 2'h1;
		cyc(2);
		chk(oe_n, 6'h32);
		chk({4'h0, tin}, 6'h02);
		$display("test gpio timer done");
		finish_test;
	end
endmodule // testbench
